// >>> logic/owd_device.sv
// Purpose: Device end: PWM duty measure and one-wire command receiver
// Assumes: Mode chosen outside by one_wire_mode; line synchronous to clk
// Notes: Reference in millivolts on ref_mv
`timescale 1ns/1ps
`default_nettype none
`include "owd_defs.svh"

// Contract
// - Constant high line gives 200 mV reference
// - PWM mode: reference is duty times full
// - Host PWM between 5 and 100 kHz
// - One command sets any of 32 levels
// - Enabled device starts at full scale
// - Level held in register, reset to full
// - Address byte then data byte, address must match
// - Data byte: level, sub-address, ack request
// - Acknowledge only if requested and received cleanly
// - Bit receiver adapts 1.7 to 160 kbit/s
// - Level code maps to pseudo-logarithmic millivolts
// - Address byte sent bit 7 first
// - Bit value from high versus low ratio
// - Host sends MSB first, start and end intervals
// - Data bit 7 ack, 6:5 sub, 4:0 level
// - Ack pulls line low, at most 512 us
module owd_device
    import owd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Mode and link
    input wire logic one_wire_mode,
    owd_link_if.device link,
    // Regulation reference
    output logic [7:0] ref_mv,
    output logic [4:0] level_code,
    output logic [1:0] sub_address,
    output logic cmd_valid,
    output logic cmd_error
);
    // ==========================================
    // State
    typedef struct packed {
        owd_rx_state_t st;
        logic line_q;
        logic [`OWD_CNT_W-1:0] t_low;
        logic [`OWD_CNT_W-1:0] t_high;
        logic [`OWD_CNT_W-1:0] t_ack;
        logic [3:0] nbits;
        logic [15:0] shift;
        logic bad;
        logic [4:0] level;
        logic [1:0] sub;
        logic valid;
        logic err;
        logic ack_on;
        logic [`OWD_PWM_WIN_W-1:0] win;
        logic [`OWD_PWM_WIN_W-1:0] hi_cnt;
        logic [`OWD_PWM_WIN_W-1:0] duty;
        logic [7:0] pwm_mv;
    } owd_dev_state_t;

    owd_dev_state_t s_q, s_d;
    logic fall, bit_one, bit_zero;
    logic frame_bad;
    logic [23:0] prod;

    // ==========================================
    // Level decode
    // Level code to millivolts
    function automatic logic [7:0] level_to_mv(input logic [4:0] c);
        logic [7:0] cw;
        cw = {3'h0, c};
        if (c == 5'h00) level_to_mv = 8'h00;
        else if (c == 5'h01) level_to_mv = 8'h05;
        else if (c <= 5'h0c) level_to_mv = 8'h08 + 8'(3 * (cw - 8'h02));
        else if (c <= 5'h17) level_to_mv = 8'h2c + 8'(6 * (cw - 8'h0d));
        else level_to_mv = 8'h74 + 8'(12 * (cw - 8'h18));
    endfunction

    // ==========================================
    // Bit timing
    assign fall = s_q.line_q && !link.line;
    // Ratio test needs no rate setting
    // Doubled count kept one bit wider, no wrap at slow rates
    assign bit_one = {1'b0, s_q.t_high} >= {s_q.t_low, 1'b0};
    assign bit_zero = {1'b0, s_q.t_low} >= {s_q.t_high, 1'b0};
    // Bad flag including the bit now closing
    assign frame_bad = s_q.bad || !(bit_one || bit_zero);
    assign prod = 24'(s_q.duty) * 24'(`OWD_FULL_SCALE_MV);

    // ==========================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.line_q = link.line;
        s_d.valid = 1'b0;
        s_d.err = 1'b0;
        // PWM duty over a fixed window, reference is duty times full scale
        s_d.win = s_q.win + 16'h0001;
        s_d.hi_cnt = s_q.hi_cnt + {15'h0, link.line};
        if (s_q.win == 16'hffff) begin
            // Full window of high saturates, no wrap to zero
            s_d.duty = (&s_q.hi_cnt) ? 16'hffff : s_q.hi_cnt + {15'h0, link.line};
            s_d.hi_cnt = 16'h0000;
        end
        s_d.pwm_mv = prod[23:16] + {7'h0, prod[15]};
        if (s_q.duty == 16'hffff) s_d.pwm_mv = `OWD_FULL_SCALE_MV;
        case (s_q.st)
            OWD_RX_IDLE: begin
                s_d.ack_on = 1'b0;
                if (one_wire_mode && fall) begin
                    s_d.st = OWD_RX_LOW;
                    s_d.t_low = '0;
                    s_d.t_high = '0;
                end
            end
            OWD_RX_LOW: begin
                if (link.line) begin
                    s_d.st = OWD_RX_HIGH;
                    s_d.t_high = `OWD_CNT_W'(1);
                end else if (&s_q.t_low) begin
                    s_d.st = OWD_RX_IDLE;
                    s_d.nbits = 4'h0;
                    s_d.bad = 1'b0;
                end else begin
                    s_d.t_low = s_q.t_low + `OWD_CNT_W'(1);
                end
            end
            OWD_RX_HIGH: begin
                if (fall) begin
                    // One bit complete, MSB first
                    s_d.shift = {s_q.shift[14:0], bit_one};
                    s_d.bad = frame_bad;
                    s_d.nbits = s_q.nbits + 4'h1;
                    s_d.t_low = '0;
                    s_d.t_high = '0;
                    s_d.st = OWD_RX_LOW;
                    // Byte closed: end-of-stream and start follow, not a bit
                    if (s_q.nbits == 4'h7) begin
                        s_d.st = OWD_RX_IDLE;
                    end
                    if (s_q.nbits == 4'hf) begin
                        s_d.st = OWD_RX_IDLE;
                        s_d.nbits = 4'h0;
                        s_d.bad = 1'b0;
                        if (!frame_bad && s_d.shift[15:8] == `OWD_DEV_ADDR) begin
                            s_d.level = s_d.shift[`OWD_LEVEL_MSB:`OWD_LEVEL_LSB];
                            s_d.sub = s_d.shift[`OWD_SUB_HI_POS:`OWD_SUB_LO_POS];
                            s_d.valid = 1'b1;
                            if (s_d.shift[`OWD_ACK_REQ_POS]) begin
                                s_d.st = OWD_RX_ACKWAIT;
                                s_d.t_ack = '0;
                            end
                        end else begin
                            s_d.err = 1'b1;
                        end
                    end
                end else if (!(&s_q.t_high)) begin
                    s_d.t_high = s_q.t_high + `OWD_CNT_W'(1);
                end
            end
            OWD_RX_ACKWAIT: begin
                // Host keeps the line low during this delay
                s_d.t_ack = s_q.t_ack + `OWD_CNT_W'(1);
                if (s_q.t_ack == `OWD_CNT_W'(`OWD_VALACK_CYC - 1)) begin
                    s_d.st = OWD_RX_ACK;
                    s_d.t_ack = '0;
                    s_d.ack_on = 1'b1;
                end
            end
            OWD_RX_ACK: begin
                s_d.t_ack = s_q.t_ack + `OWD_CNT_W'(1);
                if (s_q.t_ack == `OWD_CNT_W'(`OWD_ACK_CYC - 1)) begin
                    s_d.st = OWD_RX_IDLE;
                    s_d.ack_on = 1'b0;
                end
            end
            default: s_d.st = OWD_RX_IDLE;
        endcase
    end

    // ==========================================
    // Registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.line_q <= 1'b1;
            s_q.level <= `OWD_LEVEL_RESET;
            s_q.duty <= 16'hffff;
            s_q.pwm_mv <= `OWD_FULL_SCALE_MV;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // Outputs
    // Open drain: only ever pulls low
    assign link.dev_out = 1'b0;
    assign link.dev_oe = s_q.ack_on;
    assign ref_mv = one_wire_mode ? level_to_mv(s_q.level) : s_q.pwm_mv;
    assign level_code = s_q.level;
    assign sub_address = s_q.sub;
    assign cmd_valid = s_q.valid;
    assign cmd_error = s_q.err;
endmodule
`default_nettype wire

// >>> logic/owd_defs.svh
// Purpose: Timing counts, field positions and reset values of the one-wire dimming link
// Assumes: 250 MHz clock, 4 ns period
// Notes: Definitions only
`ifndef OWD_DEFS_SVH
`define OWD_DEFS_SVH

`define OWD_CLK_MHZ 250
// Start and end-of-stream intervals, 2 us least
`define OWD_T_START_NS 2000
`define OWD_START_CYC ((`OWD_T_START_NS * `OWD_CLK_MHZ + 999) / 1000)
`define OWD_T_EOS_NS 2000
`define OWD_EOS_CYC ((`OWD_T_EOS_NS * `OWD_CLK_MHZ + 999) / 1000)
// Acknowledge pull-down, 512 us at most
`define OWD_T_ACK_US 512
`define OWD_ACK_CYC (`OWD_T_ACK_US * `OWD_CLK_MHZ)
// Delay from last falling edge to acknowledge, 2 us chosen
`define OWD_T_VALACK_NS 2000
`define OWD_VALACK_CYC ((`OWD_T_VALACK_NS * `OWD_CLK_MHZ + 999) / 1000)
// Slowest bit at 1.7 kbit/s, about 147060 cycles; 18-bit counters suffice
`define OWD_CNT_W 18
// Host bit timing: short 1 part, long 3 parts
`define OWD_BIT_UNIT_CYC 250
// PWM accumulator window
`define OWD_PWM_WIN_W 16

// Data byte fields
`define OWD_ACK_REQ_POS 7
`define OWD_SUB_HI_POS 6
`define OWD_SUB_LO_POS 5
`define OWD_LEVEL_MSB 4
`define OWD_LEVEL_LSB 0
`define OWD_LEVEL_RESET 5'h1f
`define OWD_FULL_SCALE_MV 8'hc8
// Device address, neutral value, arbitrary
`define OWD_DEV_ADDR 8'h5a

`endif

// >>> logic/owd_pkg.sv
// Purpose: Types for the one-wire dimming link
// Assumes: Used with owd_defs.svh
// Notes: None
`default_nettype none
package owd_pkg;
    typedef enum logic [2:0] {
        OWD_RX_IDLE = 3'h0,
        OWD_RX_LOW = 3'h1,
        OWD_RX_HIGH = 3'h2,
        OWD_RX_ACKWAIT = 3'h3,
        OWD_RX_ACK = 3'h4
    } owd_rx_state_t;

    typedef enum logic [2:0] {
        OWD_TX_IDLE = 3'h0,
        OWD_TX_START = 3'h1,
        OWD_TX_LOW = 3'h2,
        OWD_TX_HIGH = 3'h3,
        OWD_TX_EOS = 3'h4,
        OWD_TX_ACKCHK = 3'h5,
        OWD_TX_ACKEND = 3'h6
    } owd_tx_state_t;
endpackage
`default_nettype wire

// >>> logic/owd_link_if.sv
// Purpose: Control line between host and dimming device
// Assumes: Line pulled high when nobody drives it low
// Notes: Open drain at the device, push or open drain at the host
`timescale 1ns/1ps
`default_nettype none
interface owd_link_if;
    logic host_out;
    logic host_oe;
    logic dev_out;
    logic dev_oe;
    logic line;
    // Wired-and with pull-up
    assign line = !((host_oe && !host_out) || (dev_oe && !dev_out));
    modport device (input line, output dev_out, output dev_oe);
    modport host (input line, output host_out, output host_oe);
endinterface
`default_nettype wire

// >>> logic/owd_host.sv
// Purpose: Host end: sends address and data bytes, checks acknowledge
// Assumes: Open-drain capable drive when acknowledge is requested
// Notes: Bit as one unit short part, three units long part
`timescale 1ns/1ps
`default_nettype none
`include "owd_defs.svh"
module owd_host
    import owd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Command request
    input wire logic cmd_start,
    input wire logic [7:0] cmd_data,
    output logic cmd_ready,
    output logic cmd_done,
    output logic ack_seen,
    // Link
    owd_link_if.host link
);
    typedef struct packed {
        owd_tx_state_t st;
        logic [15:0] shift;
        logic [4:0] nbits;
        logic [`OWD_CNT_W-1:0] cnt;
        logic ack_req;
        logic drive_low;
        logic done;
        logic ack;
    } owd_host_state_t;

    owd_host_state_t s_q, s_d;
    logic cur;

    assign cur = s_q.shift[15];

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.cnt = s_q.cnt + `OWD_CNT_W'(1);
        case (s_q.st)
            OWD_TX_IDLE: begin
                s_d.drive_low = 1'b0;
                s_d.cnt = '0;
                if (cmd_start) begin
                    // Address byte then data byte, MSB first
                    s_d.shift = {`OWD_DEV_ADDR, cmd_data};
                    s_d.ack_req = cmd_data[`OWD_ACK_REQ_POS];
                    s_d.nbits = 5'h0;
                    s_d.ack = 1'b0;
                    s_d.st = OWD_TX_START;
                end
            end
            OWD_TX_START: begin
                // High start interval
                if (s_q.cnt == `OWD_CNT_W'(`OWD_START_CYC - 1)) begin
                    s_d.st = OWD_TX_LOW;
                    s_d.cnt = '0;
                    s_d.drive_low = 1'b1;
                end
            end
            OWD_TX_LOW: begin
                // Low part: short for one, long for zero
                if (s_q.cnt == `OWD_CNT_W'((cur ? 1 : 3) * `OWD_BIT_UNIT_CYC - 1)) begin
                    s_d.st = OWD_TX_HIGH;
                    s_d.cnt = '0;
                    s_d.drive_low = 1'b0;
                end
            end
            OWD_TX_HIGH: begin
                if (s_q.cnt == `OWD_CNT_W'((cur ? 3 : 1) * `OWD_BIT_UNIT_CYC - 1)) begin
                    s_d.cnt = '0;
                    s_d.shift = {s_q.shift[14:0], 1'b0};
                    s_d.nbits = s_q.nbits + 5'h1;
                    s_d.drive_low = 1'b1;
                    s_d.st = OWD_TX_LOW;
                    if (s_q.nbits == 5'h7 || s_q.nbits == 5'hf) s_d.st = OWD_TX_EOS;
                end
            end
            OWD_TX_EOS: begin
                // Closing falling edge then end-of-stream low
                if (s_q.cnt == `OWD_CNT_W'(`OWD_EOS_CYC - 1)) begin
                    s_d.cnt = '0;
                    s_d.drive_low = 1'b0;
                    s_d.st = (s_q.nbits == 5'h10) ? (s_q.ack_req ? OWD_TX_ACKCHK : OWD_TX_IDLE) : OWD_TX_START;
                    s_d.done = (s_q.nbits == 5'h10) && !s_q.ack_req;
                end
            end
            OWD_TX_ACKCHK: begin
                // Line released, read device pull-down
                if (!link.line) s_d.ack = 1'b1;
                if (s_q.cnt == `OWD_CNT_W'(4 * `OWD_VALACK_CYC)) begin
                    s_d.st = OWD_TX_ACKEND;
                    s_d.cnt = '0;
                end
            end
            OWD_TX_ACKEND: begin
                if (link.line || s_q.cnt == `OWD_CNT_W'(`OWD_ACK_CYC)) begin
                    s_d.st = OWD_TX_IDLE;
                    s_d.done = 1'b1;
                end
            end
            default: s_d.st = OWD_TX_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Open-drain style: drive only low
    assign link.host_out = 1'b0;
    assign link.host_oe = s_q.drive_low;
    assign cmd_ready = (s_q.st == OWD_TX_IDLE);
    assign cmd_done = s_q.done;
    assign ack_seen = s_q.ack;
endmodule
`default_nettype wire

// >>> tb/owd_link_assertions.sv
// Purpose: Checker for the one-wire dimming link between host and device
// Assumes: Instantiated beside the link interface in tb_top
// Notes: Single clock domain
`timescale 1ns/1ps
`default_nettype none
`include "owd_defs.svh"
module owd_link_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link and device
    input wire logic one_wire_mode,
    input wire logic dev_out,
    input wire logic dev_oe,
    input wire logic cmd_valid,
    input wire logic cmd_error,
    input wire logic [7:0] ref_mv,
    input wire logic [4:0] level_code,
    // Host
    input wire logic cmd_done
);
    logic [17:0] since_valid_q;
    logic [17:0] oe_cnt_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    function automatic logic [7:0] mv(input logic [4:0] c);
        if (c < 5'd2) return 8'(c * 5);
        if (c <= 5'd12) return 8'(8 + 3 * (c - 2));
        if (c <= 5'd23) return 8'(44 + 6 * (c - 13));
        return 8'(116 + 12 * (c - 24));
    endfunction
    // Cycles since last command and length of acknowledge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            since_valid_q <= '1;
            oe_cnt_q <= '0;
        end else begin
            since_valid_q <= cmd_valid ? 18'h0 : (&since_valid_q ? since_valid_q : since_valid_q + 18'h1);
            oe_cnt_q <= dev_oe ? oe_cnt_q + 18'h1 : 18'h0;
        end
    end
    // ==========================================
    // Properties
    property p_reset_full; $rose(rst_n) |-> level_code == `OWD_LEVEL_RESET && ref_mv == `OWD_FULL_SCALE_MV; endproperty
    a_reset_full: assert property (p_reset_full) else $error("level not full scale after reset");
    property p_ref_decode; one_wire_mode |-> ref_mv == mv(level_code); endproperty
    a_ref_decode: assert property (p_ref_decode) else $error("reference does not match level");
    property p_load_gate; !$stable(level_code) |-> cmd_valid || $past(cmd_valid); endproperty
    a_load_gate: assert property (p_load_gate) else $error("level changed without command");
    property p_err_keeps; cmd_error |-> $stable(level_code) ##1 $stable(level_code); endproperty
    a_err_keeps: assert property (p_err_keeps) else $error("level changed on bad command");
    property p_excl; !(cmd_valid && cmd_error); endproperty
    a_excl: assert property (p_excl) else $error("valid and error together");
    property p_valid_pulse; cmd_valid |=> !cmd_valid; endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("valid longer than one cycle");
    property p_ack_delay; $rose(dev_oe) |-> since_valid_q >= 18'd495 && since_valid_q <= 18'd505; endproperty
    a_ack_delay: assert property (p_ack_delay) else $error("acknowledge not timed from command");
    property p_ack_len; dev_oe |-> oe_cnt_q <= `OWD_ACK_CYC; endproperty
    a_ack_len: assert property (p_ack_len) else $error("acknowledge too long");
    property p_open_drain; dev_oe |-> !dev_out; endproperty
    a_open_drain: assert property (p_open_drain) else $error("device drives line high");
    property p_done_pulse; cmd_done |=> !cmd_done; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
    c_valid: cover property (cmd_valid);
    c_ack: cover property ($rose(dev_oe));
    c_done: cover property (cmd_done);
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: Testbench for host and device joined over the one-wire link
// Assumes: u_device and u_dev2 in one-wire mode, u_device_c and u_device_d in PWM mode
// Notes: Second link driven by hand for a wrong address
`timescale 1ns/1ps
`default_nettype none
`include "owd_defs.svh"
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic owm = 1'b1;
    logic cmd_start = 1'b0;
    logic [7:0] cmd_data = 8'h00;
    logic [7:0] rd;
    logic cmd_ready, cmd_done, ack_seen, cmd_valid, cmd_error, error_b;
    logic [7:0] ref_mv, ref_b, ref_c, ref_d;
    logic [4:0] level_code, level_b;
    logic [1:0] sub_address;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    int nvalid = 0;
    int nerr_b = 0;
    owd_link_if link_a();
    owd_link_if link_b();
    owd_link_if link_c();
    owd_link_if link_d();
    always #2 clk = ~clk;
    owd_device u_device (.clk(clk), .rst_n(rst_n), .one_wire_mode(owm), .link(link_a), .ref_mv(ref_mv),
        .level_code(level_code), .sub_address(sub_address), .cmd_valid(cmd_valid), .cmd_error(cmd_error));
    owd_host u_host (.clk(clk), .rst_n(rst_n), .cmd_start(cmd_start), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .cmd_done(cmd_done), .ack_seen(ack_seen), .link(link_a));
    owd_device u_dev2 (.clk(clk), .rst_n(rst_n), .one_wire_mode(owm), .link(link_b), .ref_mv(ref_b),
        .level_code(level_b), .sub_address(), .cmd_valid(), .cmd_error(error_b));
    owd_device u_device_c (.clk(clk), .rst_n(rst_n), .one_wire_mode(1'b0), .link(link_c), .ref_mv(ref_c),
        .level_code(), .sub_address(), .cmd_valid(), .cmd_error());
    owd_device u_device_d (.clk(clk), .rst_n(rst_n), .one_wire_mode(1'b0), .link(link_d), .ref_mv(ref_d),
        .level_code(), .sub_address(), .cmd_valid(), .cmd_error());
    owd_link_checker u_chk (.clk(clk), .rst_n(rst_n), .one_wire_mode(owm), .dev_out(link_a.dev_out),
        .dev_oe(link_a.dev_oe), .cmd_valid(cmd_valid), .cmd_error(cmd_error), .ref_mv(ref_mv),
        .level_code(level_code), .cmd_done(cmd_done));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cmd_valid === 1'b1) nvalid <= nvalid + 1;
        if (error_b === 1'b1) nerr_b <= nerr_b + 1;
        if (cyc == 95000) begin
            failures = failures + 1;
            $display("wrong value at %0t: run did not finish", $time);
            report_and_stop();
        end
    end
    // ==========================================
    // Helpers
    function automatic logic [7:0] mv_of(input logic [4:0] c);
        if (c < 5'd2) return 8'(c * 5);
        if (c <= 5'd12) return 8'(8 + 3 * (c - 2));
        if (c <= 5'd23) return 8'(44 + 6 * (c - 13));
        return 8'(116 + 12 * (c - 24));
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Bit: short low and long high for one, the reverse for zero
    task automatic send_byte_b(input logic [7:0] v);
        link_b.host_out = 1'b1;
        wait_n(`OWD_START_CYC);
        for (int i = 7; i >= 0; i--) begin
            link_b.host_out = 1'b0;
            wait_n(v[i] ? 250 : 750);
            link_b.host_out = 1'b1;
            wait_n(v[i] ? 750 : 250);
        end
        link_b.host_out = 1'b0;
        wait_n(`OWD_EOS_CYC);
    endtask
    task automatic host_cmd(input logic [7:0] d);
        check(cmd_ready, 1'b1, "ready");
        cmd_data = d;
        cmd_start = 1'b1;
        @(negedge clk);
        cmd_start = 1'b0;
    endtask
    task automatic run_cmd(input logic [7:0] d);
        host_cmd(d);
        for (int i = 0; i < 30000 && cmd_done !== 1'b1; i++) @(negedge clk);
        check(cmd_done, 1'b1, "done");
        check(ack_seen, 1'b0, "ack");
        check(level_code, d[4:0], "level");
        check(sub_address, d[6:5], "sub address");
        check(ref_mv, mv_of(d[4:0]), "reference");
        $display("test done: command %0h", d);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        link_b.host_oe = 1'b1;
        link_b.host_out = 1'b1;
        link_c.host_oe = 1'b0;
        link_c.host_out = 1'b1;
        link_d.host_oe = 1'b1;
        link_d.host_out = 1'b1;
        void'($urandom(32'h3501));
        rd = 8'($urandom) & 8'h7f;
        wait_n(20);
        rst_n = 1'b1;
        wait_n(2);
        check(level_code, `OWD_LEVEL_RESET, "reset level");
        check(ref_mv, `OWD_FULL_SCALE_MV, "reset reference");
        $display("test done: reset");
        fork
            begin
                run_cmd(8'h00);
                run_cmd(rd);
                check(nvalid, 2, "command count");
            end
            begin
                send_byte_b(`OWD_DEV_ADDR ^ 8'h81);
                send_byte_b(8'h8c);
                link_b.host_out = 1'b1;
                wait_n(10);
                check(nerr_b, 1, "wrong address error");
                check(level_b, `OWD_LEVEL_RESET, "level kept");
                check(ref_b, `OWD_FULL_SCALE_MV, "reference kept");
                check(link_b.dev_oe, 1'b0, "no ack");
                $display("test done: wrong address");
            end
            begin
                // Host PWM at 50 kHz, quarter duty
                repeat (13) begin
                    link_d.host_out = 1'b0;
                    wait_n(3750);
                    link_d.host_out = 1'b1;
                    wait_n(1250);
                end
                wait_n(600);
                check(ref_c, `OWD_FULL_SCALE_MV, "constant high reference");
                check(ref_d >= 8'd49 && ref_d <= 8'd52, 1'b1, "quarter duty reference");
                $display("test done: pwm");
            end
        join
        host_cmd(8'h8c);
        for (int i = 0; i < 30000 && link_a.dev_oe !== 1'b1; i++) @(negedge clk);
        check(link_a.dev_oe, 1'b1, "ack drive");
        check(level_code, 5'd12, "ack level");
        check(ref_mv, mv_of(5'd12), "ack reference");
        check(link_a.line, 1'b0, "line low");
        wait_n(1000);
        check(link_a.dev_oe, 1'b1, "ack held");
        check(ack_seen, 1'b1, "ack seen by host");
        $display("test done: acknowledge");
        report_and_stop();
    end
endmodule
`default_nettype wire
